// ---- rtl/overtravel_estop_stop_control.sv ----
// Implementation choices: register access over APB and the register addresses.
`default_nettype none
// Behaviour
// - forward limit off blocks forward, flags overtravel
// - reverse limit off blocks reverse, flags overtravel
// - forward disable ignores input, applied at restart
// - reverse disable ignores input
// - no code 1 or 2 allocated disables overtravel
// - active limit stops the motor only for a run command toward that limit
// - direction select swaps command and rotation
// - allocated estop off enters forced stop
// - method 0 uses profile quick-stop objects
// - method 1 uses own mode and time
// - mode 0..6; 3 and 4 map to 0
// - decel time 0..65535 ms, default 1000
// - servo-on during estop keeps stop latched
// - estop input excludes control-word quick stop
// - axis B addresses displaced by 0x800
// - overtravel stop selector picks brake behaviour
module overtravel_estop_stop_control
  import stop_ctrl_pkg::*;
#(
  parameter int INPUTS = 8
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // digital inputs and host commands
  input wire logic [INPUTS-1:0] DIN,
  input wire logic CMD_DIR,
  input wire logic CMD_RUN,
  input wire logic SERVO_ON,
  input wire logic QUICK_STOP_CW,
  // stop outputs
  output logic MOTOR_DIR,
  output logic MOTOR_RUN_EN,
  output logic FORCED_STOP,
  output logic FWD_OVERTRAVEL,
  output logic REV_OVERTRAVEL,
  output logic USE_PROFILE_DECEL,
  output logic [2:0] QUICK_STOP_CODE,
  output logic [15:0] DECEL_TIME_MS,
  output logic DYN_BRAKE,
  output logic REVERSE_BRAKE,
  output logic ZERO_CLAMP,
  output logic COAST,
  output logic [15:0] OBJ_BASE,
  output logic IRQ
);
  logic [7:0] config_reg;
  logic [7:0] config_live;
  logic [31:0] alloc;
  logic [2:0] fs_mode;
  logic [15:0] fs_decel;
  logic axis_b;
  logic [3:0] event_flags;
  logic [3:0] mask;
  logic [INPUTS-1:0] sync1;
  logic [INPUTS-1:0] sync2;
  logic [INPUTS-1:0] filt;
  logic [7:0] cnt [INPUTS];
  logic restart_done;
  stop_state_t state;
  logic fwd_alloc, rev_alloc, est_alloc;
  logic fwd_in, rev_in, est_in;
  logic fwd_ot, rev_ot, est_off;
  logic [3:0] new_events;
  logic apb_wr, apb_rd;
  logic [31:0] next_rdata;
  logic servo_on_d;
  logic restart_req;
  logic [3:0] event_lvl;
  logic [3:0] event_rise;

  assign apb_wr = PSEL && PENABLE && PWRITE;
  assign apb_rd = PSEL && PENABLE && !PWRITE;
  assign restart_req = apb_wr && PADDR == OFS_CONTROL && PWDATA[0];

  // two-stage sync then stable-count filter per input
  genvar gi;
  generate
    for (gi = 0; gi < INPUTS; gi++) begin : g_in
      always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          filt[gi] <= 1'b0;
          cnt[gi] <= 8'h00;
        end else begin
          sync1[gi] <= DIN[gi];
          sync2[gi] <= sync1[gi];
          if (sync2[gi] == filt[gi]) begin
            cnt[gi] <= 8'h00;
          end else if (cnt[gi] == 8'(FILTER_CYCLES - 1)) begin
            filt[gi] <= sync2[gi];
            cnt[gi] <= 8'h00;
          end else begin
            cnt[gi] <= cnt[gi] + 8'h01;
          end
        end
      end
    end
  endgenerate

  // allocation decode: nibble i of alloc holds function code of input i
  always_comb begin
    fwd_alloc = 1'b0;
    rev_alloc = 1'b0;
    est_alloc = 1'b0;
    fwd_in = 1'b1;
    rev_in = 1'b1;
    est_in = 1'b1;
    for (int i = 0; i < INPUTS && i < 8; i++) begin
      if (alloc[i*4 +: 4] == FUNC_FWD_LIMIT) begin
        fwd_alloc = 1'b1;
        fwd_in = filt[i];
      end else if (alloc[i*4 +: 4] == FUNC_REV_LIMIT) begin
        rev_alloc = 1'b1;
        rev_in = filt[i];
      end else if (alloc[i*4 +: 4] == FUNC_ESTOP) begin
        est_alloc = 1'b1;
        est_in = filt[i];
      end
    end
  end

  // input off means overtravel; disabled or unallocated never trips
  assign fwd_ot = fwd_alloc && !config_live[CFG_FWD_DIS] && !fwd_in;
  assign rev_ot = rev_alloc && !config_live[CFG_REV_DIS] && !rev_in;
  // quick stop from control word only when no estop input exists
  assign est_off = est_alloc ? !est_in : QUICK_STOP_CW;
  assign new_events = {SERVO_ON && est_off, est_off && state == RUN, rev_ot, fwd_ot};
  assign event_rise = new_events & ~event_lvl;

  // restart-effective settings copied once after reset release or a soft restart;
  // a hard reset also clears the staged settings, so only the soft restart applies them
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      config_live <= CONFIG_RST;
      restart_done <= 1'b0;
    end else if (restart_req) begin
      restart_done <= 1'b0;
    end else if (!restart_done) begin
      config_live <= config_reg;
      restart_done <= 1'b1;
    end
  end

  // register writes
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      config_reg <= CONFIG_RST;
      alloc <= ALLOC_RST;
      fs_mode <= FS_MODE_RST;
      fs_decel <= FS_DECEL_RST;
      mask <= 4'h0;
      axis_b <= 1'b0;
    end else if (apb_wr) begin
      if (PADDR == OFS_CONFIG) begin
        config_reg <= PWDATA[7:0];
      end else if (PADDR == OFS_ALLOC) begin
        alloc <= PWDATA;
      end else if (PADDR == OFS_STOPCFG) begin
        if (PWDATA[2:0] <= FS_MODE_MAX) begin
          fs_mode <= PWDATA[2:0];
        end
        fs_decel <= PWDATA[31:16];
      end else if (PADDR == OFS_MASK) begin
        mask <= PWDATA[3:0];
      end else if (PADDR == OFS_AXIS_SEL) begin
        axis_b <= PWDATA[0];
      end
    end
  end

  // forced-stop state machine
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state <= RUN;
      servo_on_d <= 1'b0;
    end else begin
      servo_on_d <= SERVO_ON;
      case (state)
        RUN: begin
          if (est_off) begin
            state <= STOPPING;
          end
        end
        STOPPING: begin
          if (est_off && SERVO_ON && !servo_on_d) begin
            state <= LATCHED;
          end else if (!est_off && !SERVO_ON) begin
            state <= RUN;
          end else if (!est_off && SERVO_ON) begin
            state <= LATCHED;
          end
        end
        LATCHED: begin
          // host must drop servo-on with estop released
          if (!est_off && !SERVO_ON) begin
            state <= RUN;
          end
        end
        default: state <= RUN;
      endcase
    end
  end

  // only a rising condition is an event, so a limit held open does not refire after a read
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      event_lvl <= 4'h0;
    end else begin
      event_lvl <= new_events;
    end
  end

  // sticky events; set wins over read-clear
  // clear only the bits the read returned, so an event raised in the setup cycle survives
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      event_flags <= 4'h0;
    end else if (apb_rd && PADDR == OFS_EVENT) begin
      event_flags <= (event_flags & ~PRDATA[3:0]) | event_rise;
    end else begin
      event_flags <= event_flags | event_rise;
    end
  end

  // apb read mux
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (PADDR == OFS_CONFIG) begin
      next_rdata = {24'h000000, config_reg};
    end else if (PADDR == OFS_ALLOC) begin
      next_rdata = alloc;
    end else if (PADDR == OFS_STOPCFG) begin
      next_rdata = {fs_decel, 13'h0000, fs_mode};
    end else if (PADDR == OFS_STATUS) begin
      next_rdata = {26'h0000000, state, est_off, rev_ot, fwd_ot, restart_done};
    end else if (PADDR == OFS_EVENT) begin
      next_rdata = {28'h0000000, event_flags};
    end else if (PADDR == OFS_MASK) begin
      next_rdata = {28'h0000000, mask};
    end else if (PADDR == OFS_AXIS_SEL) begin
      next_rdata = {31'h00000000, axis_b};
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && !PENABLE;
      PRDATA <= next_rdata;
      PSLVERR <= PSEL && !PENABLE && !(PADDR == OFS_CONFIG || PADDR == OFS_ALLOC ||
        PADDR == OFS_STOPCFG || PADDR == OFS_CONTROL || PADDR == OFS_STATUS ||
        PADDR == OFS_EVENT || PADDR == OFS_MASK || PADDR == OFS_AXIS_SEL);
    end
  end

  // motion and stop outputs
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      MOTOR_DIR <= 1'b0;
      MOTOR_RUN_EN <= 1'b0;
      FORCED_STOP <= 1'b0;
      FWD_OVERTRAVEL <= 1'b0;
      REV_OVERTRAVEL <= 1'b0;
      USE_PROFILE_DECEL <= 1'b1;
      QUICK_STOP_CODE <= 3'h0;
      DECEL_TIME_MS <= FS_DECEL_RST;
      DYN_BRAKE <= 1'b0;
      REVERSE_BRAKE <= 1'b0;
      ZERO_CLAMP <= 1'b0;
      COAST <= 1'b0;
      OBJ_BASE <= 16'h0000;
      IRQ <= 1'b0;
    end else begin
      // 0 = ccw forward; 1 swaps
      MOTOR_DIR <= CMD_DIR ^ config_live[CFG_DIR];
      MOTOR_RUN_EN <= CMD_RUN && state == RUN &&
        !((!CMD_DIR && fwd_ot) || (CMD_DIR && rev_ot));
      FORCED_STOP <= state != RUN;
      FWD_OVERTRAVEL <= fwd_ot;
      REV_OVERTRAVEL <= rev_ot;
      USE_PROFILE_DECEL <= !config_live[CFG_FS_METHOD];
      QUICK_STOP_CODE <= (fs_mode == 3'h3 || fs_mode == 3'h4) ? 3'h0 : fs_mode;
      DECEL_TIME_MS <= fs_decel;
      OBJ_BASE <= axis_b ? AXIS_B_OFFSET : 16'h0000;
      // overtravel brake style, only while a limit blocks the command
      if (CMD_RUN && ((!CMD_DIR && fwd_ot) || (CMD_DIR && rev_ot))) begin
        DYN_BRAKE <= config_live[CFG_OT_SEL +: 2] <= 2'h1;
        REVERSE_BRAKE <= config_live[CFG_OT_SEL +: 2] >= 2'h2;
        ZERO_CLAMP <= config_live[CFG_OT_SEL +: 2] == 2'h2;
        COAST <= config_live[CFG_OT_SEL +: 2] == 2'h0 || config_live[CFG_OT_SEL +: 2] == 2'h3;
      end else begin
        DYN_BRAKE <= 1'b0;
        REVERSE_BRAKE <= 1'b0;
        ZERO_CLAMP <= 1'b0;
        COAST <= 1'b0;
      end
      IRQ <= |(event_flags & mask);
    end
  end

  fwd_block_a: assert property (@(posedge CLK) disable iff (RESET)
    (CMD_RUN && !CMD_DIR && fwd_ot) |=> !MOTOR_RUN_EN)
    else $error("forward run not blocked");
  rev_block_a: assert property (@(posedge CLK) disable iff (RESET)
    (CMD_RUN && CMD_DIR && rev_ot) |=> !MOTOR_RUN_EN)
    else $error("reverse run not blocked");
  fwd_disable_a: assert property (@(posedge CLK) disable iff (RESET)
    config_live[CFG_FWD_DIS] |=> !FWD_OVERTRAVEL)
    else $error("disabled forward limit tripped");
  rev_disable_a: assert property (@(posedge CLK) disable iff (RESET)
    config_live[CFG_REV_DIS] |=> !REV_OVERTRAVEL)
    else $error("disabled reverse limit tripped");
  unalloc_off_a: assert property (@(posedge CLK) disable iff (RESET)
    (!fwd_alloc && !rev_alloc) |=> (!FWD_OVERTRAVEL && !REV_OVERTRAVEL))
    else $error("unallocated limit tripped");
  run_block_a: assert property (@(posedge CLK) disable iff (RESET)
    (state != RUN) |=> !MOTOR_RUN_EN)
    else $error("run allowed during forced stop");
  dir_map_a: assert property (@(posedge CLK) disable iff (RESET)
    1'b1 |=> MOTOR_DIR == ($past(CMD_DIR) ^ $past(config_live[CFG_DIR])))
    else $error("direction map wrong");
  estop_stop_a: assert property (@(posedge CLK) disable iff (RESET)
    (est_off && state == RUN) |=> ##1 FORCED_STOP)
    else $error("estop not forcing stop");
  method_sel_a: assert property (@(posedge CLK) disable iff (RESET)
    1'b1 |=> USE_PROFILE_DECEL == !$past(config_live[CFG_FS_METHOD]))
    else $error("stop method select wrong");
  decel_pass_a: assert property (@(posedge CLK) disable iff (RESET)
    1'b1 |=> DECEL_TIME_MS == $past(fs_decel))
    else $error("decel time not applied");
  latch_hold_a: assert property (@(posedge CLK) disable iff (RESET)
    (state == LATCHED && SERVO_ON) |=> state == LATCHED)
    else $error("latch left under servo on");
  qs_excl_a: assert property (@(posedge CLK) disable iff (RESET)
    (est_alloc && est_in && state == RUN) |=> state == RUN)
    else $error("control word stop with estop input");
  code_map_a: assert property (@(posedge CLK) disable iff (RESET)
    (fs_mode == 3'h3 || fs_mode == 3'h4) |=> QUICK_STOP_CODE == 3'h0)
    else $error("mode code wrong");
  axis_base_a: assert property (@(posedge CLK) disable iff (RESET)
    axis_b |=> OBJ_BASE == AXIS_B_OFFSET)
    else $error("axis b base wrong");
  event_set_a: assert property (@(posedge CLK) disable iff (RESET)
    (apb_rd && PADDR == OFS_EVENT && event_rise[0]) |=> event_flags[0])
    else $error("event lost on read clear");
  irq_level_a: assert property (@(posedge CLK) disable iff (RESET)
    (|(event_flags & mask)) |=> IRQ)
    else $error("irq not raised");
  apb_ready_a: assert property (@(posedge CLK) disable iff (RESET)
    (PSEL && !PENABLE) |=> PREADY)
    else $error("apb not ready");
  latch_c: cover property (@(posedge CLK) disable iff (RESET) state == LATCHED);
  method_c: cover property (@(posedge CLK) disable iff (RESET) !USE_PROFILE_DECEL);
  fwd_ot_c: cover property (@(posedge CLK) disable iff (RESET) FWD_OVERTRAVEL && DYN_BRAKE);
  clamp_c: cover property (@(posedge CLK) disable iff (RESET) ZERO_CLAMP);
  irq_c: cover property (@(posedge CLK) disable iff (RESET) IRQ);
endmodule
`default_nettype wire

// ---- rtl/stop_ctrl_pkg.sv ----
`default_nettype none
package stop_ctrl_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_ALLOC = 8'h04;
  localparam logic [7:0] OFS_STOPCFG = 8'h08;
  localparam logic [7:0] OFS_CONTROL = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_EVENT = 8'h14;
  localparam logic [7:0] OFS_MASK = 8'h18;
  localparam logic [7:0] OFS_AXIS_SEL = 8'h1C;
  // config field positions
  localparam int CFG_FWD_DIS = 0;
  localparam int CFG_REV_DIS = 1;
  localparam int CFG_DIR = 2;
  localparam int CFG_OT_SEL = 4;
  localparam int CFG_FS_METHOD = 6;
  // input function codes
  localparam logic [3:0] FUNC_FWD_LIMIT = 4'h1;
  localparam logic [3:0] FUNC_REV_LIMIT = 4'h2;
  localparam logic [3:0] FUNC_ESTOP = 4'hA;
  // reset values
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [31:0] ALLOC_RST = 32'h0000_0021;
  localparam logic [2:0] FS_MODE_RST = 3'h0;
  localparam logic [15:0] FS_DECEL_RST = 16'h03E8;
  localparam logic [2:0] FS_MODE_MAX = 3'h6;
  // axis B object address displacement
  localparam logic [15:0] AXIS_B_OFFSET = 16'h0800;
  // input filter
  localparam int FILTER_NS = 1000;
  localparam int CLK_NS = 10;
  localparam int FILTER_CYCLES = (FILTER_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {RUN, STOPPING, LATCHED} stop_state_t;
endpackage
`default_nettype wire

// ---- tb/limit_host_model.sv ----
`default_nettype none
module limit_host_model (
  // clock
  input wire logic clk,
  // switch levels, high = closed
  input wire logic fwd_ok,
  input wire logic rev_ok,
  input wire logic estop_ok,
  // host requests
  input wire logic servo_req,
  input wire logic recover,
  input wire logic forced_stop,
  // to drive
  output logic [7:0] din,
  output logic servo_on
);
  timeunit 1ns;
  timeprecision 1ps;
  // spare inputs carry a fixed mixed pattern, so unallocated pins are not all quiet
  assign din = {5'h15, estop_ok, rev_ok, fwd_ok};
  // a recovery holds servo off until the drive reports ready, then enables again
  always_ff @(posedge clk) begin
    servo_on <= servo_req & ~(recover & forced_stop);
  end
endmodule
`default_nettype wire

// ---- tb/tb_overtravel_estop_stop_control.sv ----
`default_nettype none
module tb_overtravel_estop_stop_control;
  import stop_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, slv;
  logic fwd_ok = 1, rev_ok = 1, estop_ok = 1, servo_req = 0, recover = 0;
  logic cmd_dir = 0, cmd_run = 0, qs_cw = 0, servo_on;
  logic [7:0] din;
  logic mdir, run_en, forced, fwd_ot, rev_ot, use_prof, dyn_brake, rev_brake, zclamp, coast, irq;
  logic [2:0] qs_code;
  logic [15:0] decel, obj_base;
  logic [2:0] exp_code;
  int err_count = 0, tests_run = 0;
  always #5 clk = ~clk;
  limit_host_model partner (.clk(clk), .fwd_ok(fwd_ok), .rev_ok(rev_ok), .estop_ok(estop_ok),
    .servo_req(servo_req), .recover(recover), .forced_stop(forced), .din(din), .servo_on(servo_on));
  overtravel_estop_stop_control dut (.CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .DIN(din), .CMD_DIR(cmd_dir), .CMD_RUN(cmd_run), .SERVO_ON(servo_on),
    .QUICK_STOP_CW(qs_cw), .MOTOR_DIR(mdir), .MOTOR_RUN_EN(run_en), .FORCED_STOP(forced),
    .FWD_OVERTRAVEL(fwd_ot), .REV_OVERTRAVEL(rev_ot), .USE_PROFILE_DECEL(use_prof),
    .QUICK_STOP_CODE(qs_code), .DECEL_TIME_MS(decel), .DYN_BRAKE(dyn_brake),
    .REVERSE_BRAKE(rev_brake), .ZERO_CLAMP(zclamp), .COAST(coast), .OBJ_BASE(obj_base), .IRQ(irq));
  task stop_test();
    if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    slv = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // long enough for sync, filter and the registered outputs
  task wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    reset <= 0;
    wt(1);
    chk("use_profile", 1, use_prof);
    chk("decel_rst", 32'h03E8, decel);
    wt(120);
    apb(0, OFS_STOPCFG, 0);
    chk("stopcfg", 32'h03E8_0000, rdv);
    apb(0, OFS_ALLOC, 0);
    chk("alloc", ALLOC_RST, rdv);
    apb(0, 8'h20, 0);
    chk("slverr", 1, slv);
    apb(0, OFS_EVENT, 0);
    apb(1, OFS_MASK, 32'h1);
    @(posedge clk) cmd_run <= 1;
    fwd_ok <= 0;
    wt(120);
    chk("fwd_ot", 1, fwd_ot);
    chk("run_en_fwd", 0, run_en);
    chk("dyn_brake", 1, dyn_brake);
    chk("zero_clamp", 0, zclamp);
    chk("irq_on", 1, irq);
    apb(0, OFS_EVENT, 0);
    chk("event", 32'h1, rdv);
    wt(2);
    chk("irq_off", 0, irq);
    @(posedge clk) cmd_dir <= 1;
    wt(3);
    chk("run_en_rev", 1, run_en);
    chk("mdir", 1, mdir);
    @(posedge clk) fwd_ok <= 1;
    rev_ok <= 0;
    wt(120);
    chk("rev_ot", 1, rev_ot);
    chk("run_en_rblk", 0, run_en);
    apb(1, OFS_CONFIG, 32'h4);
    apb(1, OFS_CONTROL, 32'h1);
    wt(3);
    chk("mdir_swap", 0, mdir);
    apb(1, OFS_CONFIG, 32'h64);
    apb(1, OFS_CONTROL, 32'h1);
    wt(3);
    chk("zero_clamp_on", 1, zclamp);
    chk("rev_brake", 1, rev_brake);
    chk("dyn_brake_off", 0, dyn_brake);
    chk("coast_off", 0, coast);
    chk("use_profile_off", 0, use_prof);
    apb(1, OFS_CONFIG, 32'h66);
    apb(1, OFS_CONTROL, 32'h1);
    wt(3);
    chk("rev_dis", 0, rev_ot);
    chk("run_en_rdis", 1, run_en);
    @(posedge clk) rev_ok <= 1;
    exp_code = 3'h0;
    for (int m = 0; m < 8; m++) begin
      apb(1, OFS_STOPCFG, {16'(m + 1), 16'(m)});
      if (m < 7) exp_code = (m == 3 || m == 4) ? 3'h0 : 3'(m);
      wt(3);
      chk("qs_code", exp_code, qs_code);
      chk("decel", 32'(m + 1), decel);
    end
    @(posedge clk) qs_cw <= 1;
    wt(5);
    chk("qs_stop", 1, forced);
    @(posedge clk) qs_cw <= 0;
    wt(5);
    chk("qs_release", 0, forced);
    apb(1, OFS_ALLOC, 32'h0A21);
    @(posedge clk) qs_cw <= 1;
    wt(5);
    chk("qs_ignored", 0, forced);
    @(posedge clk) qs_cw <= 0;
    estop_ok <= 0;
    wt(120);
    chk("estop_stop", 1, forced);
    @(posedge clk) servo_req <= 1;
    wt(5);
    @(posedge clk) estop_ok <= 1;
    wt(120);
    chk("latched", 1, forced);
    apb(0, OFS_STATUS, 0);
    chk("state", 2, rdv[5:4]);
    apb(0, OFS_EVENT, 0);
    chk("event_estop", 32'hE, rdv);
    @(posedge clk) recover <= 1;
    wt(10);
    chk("recovered", 0, forced);
    chk("servo_back", 1, servo_on);
    @(posedge clk) recover <= 0;
    apb(1, OFS_AXIS_SEL, 32'h1);
    wt(3);
    chk("obj_base", AXIS_B_OFFSET, obj_base);
    apb(1, OFS_ALLOC, 32'h0);
    @(posedge clk) fwd_ok <= 0;
    wt(120);
    chk("ot_unalloc", 0, fwd_ot);
    apb(1, OFS_ALLOC, 32'h21);
    wt(3);
    chk("ot_realloc", 1, fwd_ot);
    apb(1, OFS_CONFIG, 32'h67);
    apb(1, OFS_CONTROL, 32'h1);
    wt(3);
    chk("fwd_dis", 0, fwd_ot);
    stop_test();
  end
endmodule
`default_nettype wire
